/* hw/sdc_dev.sv */
`timescale 1ns/10ps
module sdc_dev
  import sdc_pkg::*;
#(
  parameter int unsigned OD_CYC = OD_DELAY_CYC,
  parameter int unsigned WAKE_CYC = WAKE_RST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  sdc_link_if.dev link,
  input wire logic vcc_wake,
  input wire logic cell_below_uv,
  input wire logic cells_above_ce,
  output logic charge_fet_drive,
  output logic discharge_fet_drive,
  output logic regulated_supply_out,
  output logic [1:0] charge_enable_threshold_sel,
  output logic asleep,
  output logic od_protect
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [1:0] wake_s;
  logic [1:0] uv_s;
  logic [1:0] ce_s;
  logic sck_p_q;
  logic cs_p_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      wake_s <= 2'h0;
      uv_s <= 2'h0;
      ce_s <= 2'h0;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], link.sck};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      wake_s <= {wake_s[0], vcc_wake};
      uv_s <= {uv_s[0], cell_below_uv};
      ce_s <= {ce_s[0], cells_above_ce};
      sck_p_q <= sck_s[1];
      cs_p_q <= cs_s[1];
    end
  end

  wire sck_rise = sck_s[1] & ~sck_p_q;
  wire cs_rise = cs_s[1] & ~cs_p_q;
  wire wake_lvl = wake_s[1];
  wire uv_lvl = uv_s[1];
  wire ce_lvl = ce_s[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  sdc_dev_st_t st_q;
  sdc_dev_st_t st_d;
  logic [31:0] od_cnt_q;
  logic [31:0] wk_cnt_q;
  logic od_q;
  logic chg_q;
  logic dsg_q;
  logic [1:0] cfg_sel_q;
  logic cfg_gate_q;
  logic [15:0] sh_q;
  logic [4:0] bits_q;

  wire in_run = (st_q == DEV_RUN);
  wire in_sleep = (st_q == DEV_SLEEP);
  wire in_wrst = (st_q == DEV_WRST);

  // ----------------------------------------
  // Serial receive
  // ----------------------------------------
  // Port is dead while powered down, so frames then are lost whole
  wire spi_on = ~in_sleep; // [R15]
  wire frame_done = spi_on & cs_rise & (bits_q == 5'(FRAME_BITS));
  wire [7:0] instr = sh_q[15:8];
  wire [7:0] dat = sh_q[7:0];
  wire ctrl_wr = frame_done & (instr == CONTROL_WRITE_INSTR);
  wire cfg_wr = frame_done & (instr == CONFIG_WRITE_INSTR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 16'h0000;
      bits_q <= 5'h00;
    end else if (!spi_on || cs_s[1]) begin
      bits_q <= 5'h00;
    end else if (sck_rise) begin
      sh_q <= {sh_q[14:0], mosi_s[1]};
      if (bits_q != 5'(FRAME_BITS)) begin
        bits_q <= bits_q + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sel_q <= CFG_SEL_RST;
      cfg_gate_q <= CFG_GATE_RST;
    end else if (cfg_wr) begin
      cfg_sel_q <= dat[CFG_SEL_LSB +: 2]; // [R7]
      cfg_gate_q <= dat[CFG_GATE_BIT]; // [R8] [R10]
    end
  end

  // Gate switched off (bit one) means zero threshold: every cell passes
  wire ce_ok = cfg_gate_q | ce_lvl; // [R8] [R10] [R5]

  // ----------------------------------------
  // Over-discharge detection timer
  // ----------------------------------------
  wire od_expire = in_run & uv_lvl & ~od_q & (od_cnt_q == 32'(OD_CYC - 1)); // [R14]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_cnt_q <= 32'h0000_0000;
    end else if (!in_run || !uv_lvl || od_q) begin
      od_cnt_q <= 32'h0000_0000; // [R16]
    end else if (!od_expire) begin
      od_cnt_q <= od_cnt_q + 32'h0000_0001; // [R13]
    end
  end

  // ----------------------------------------
  // Sleep entry and wake
  // ----------------------------------------
  wire slp_req = ctrl_wr & dat[CTRL_SLP_BIT]; // [R1]
  // Refused request is dropped, not held for later
  wire go_sleep = in_run & ~wake_lvl & (slp_req | od_expire); // [R1] [R9] [R14]
  wire wrst_done = in_wrst & (wk_cnt_q == 32'(WAKE_CYC - 1)); // [R17]

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DEV_RUN: begin
        if (go_sleep) begin
          st_d = DEV_SLEEP;
        end
      end
      DEV_SLEEP: begin
        if (wake_lvl) begin
          st_d = DEV_WRST; // [R4]
        end
      end
      DEV_WRST: begin
        if (wrst_done) begin
          st_d = DEV_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= DEV_RUN;
      wk_cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      wk_cnt_q <= in_wrst ? wk_cnt_q + 32'h0000_0001 : 32'h0000_0000; // [R17]
    end
  end

  // ----------------------------------------
  // FET control bits and protection flag
  // ----------------------------------------
  // Writes during sleep or the wake reset window never reach the bits
  wire fet_wr = ctrl_wr & in_run; // [R3] [R17]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_q <= 1'b0;
      dsg_q <= 1'b0;
    end else if (go_sleep || od_expire) begin
      chg_q <= 1'b0; // [R11] [R14]
      dsg_q <= 1'b0; // [R12] [R14]
    end else if (fet_wr) begin
      chg_q <= dat[CTRL_CHG_BIT]; // [R11]
      dsg_q <= dat[CTRL_DSG_BIT]; // [R12]
    end
  end

  // Protection ends only when host turns discharge back on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_q <= 1'b0;
    end else if (od_expire) begin
      od_q <= 1'b1; // [R14]
    end else if (fet_wr && dat[CTRL_DSG_BIT]) begin
      od_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Drive high means FET off
  wire fet_allow = in_run & ~go_sleep & ~od_expire & ~od_q & ce_ok; // [R2] [R5] [R6]
  wire chg_on_d = fet_allow & chg_q; // [R11]
  wire dsg_on_d = fet_allow & dsg_q; // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_fet_drive <= 1'b1;
      discharge_fet_drive <= 1'b1;
      regulated_supply_out <= 1'b1;
      charge_enable_threshold_sel <= CFG_SEL_RST;
      asleep <= 1'b0;
      od_protect <= 1'b0;
    end else begin
      charge_fet_drive <= ~chg_on_d;
      discharge_fet_drive <= ~dsg_on_d;
      regulated_supply_out <= (st_d != DEV_SLEEP); // [R2] [R4]
      charge_enable_threshold_sel <= cfg_sel_q;
      asleep <= (st_d == DEV_SLEEP); // [R2]
      od_protect <= od_q | od_expire;
    end
  end

endmodule

/* hw/sdc_pkg.sv */
// Operation
// [R1] Sleep on over-discharge or sleep request bit
// [R2] Sleep: FETs off, regulated output off
// [R3] Sleep: FET control bit writes ignored
// [R4] Wake at wake threshold, restore output, serial
// [R5] On wake, check cells above charge threshold
// [R6] Any cell below threshold holds both FETs off
// [R7] Host selects threshold via two-bit config field
// [R8] Gate switch off means threshold is zero
// [R9] No sleep while supply at wake threshold
// [R10] Gate switch bit one lets charging resume
// [R11] Charge FET off until host writes one
// [R12] Discharge FET off until host writes one
// [R13] Cell under threshold starts detection timer
// [R14] Timer expiry: FETs off, protect, sleep together; code skips the sleep while vcc_wake is high
// [R15] Asleep in protection: serial access ignored
// [R16] Cells recover before expiry: timer cancelled
// [R17] Wake reset delay; no FET writes then
package sdc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int OD_DELAY_MS = 1000;
  localparam int OC_DELAY_MS = 1000;
  localparam int WAKE_EXTRA_MS = 200;
  localparam int LONG_DELAY_MS = (OD_DELAY_MS > OC_DELAY_MS) ? OD_DELAY_MS : OC_DELAY_MS;
  localparam int OD_DELAY_CYC = OD_DELAY_MS * (CLK_HZ / 1000);
  localparam int WAKE_RST_CYC = (LONG_DELAY_MS + WAKE_EXTRA_MS) * (CLK_HZ / 1000);
  localparam int SPI_HALF_CYC = 8;

  // ----------------------------------------
  // Serial frame: instruction byte, data byte
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [7:0] CONTROL_WRITE_INSTR = 8'h02;
  localparam logic [7:0] CONFIG_WRITE_INSTR = 8'h06;

  // Control byte fields
  localparam int CTRL_CHG_BIT = 0;
  localparam int CTRL_DSG_BIT = 1;
  localparam int CTRL_SLP_BIT = 7;
  // Config byte fields
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_GATE_BIT = 2;
  localparam logic [1:0] CFG_SEL_RST = 2'h0;
  localparam logic CFG_GATE_RST = 1'b0;

  // ----------------------------------------
  // Host APB map
  // ----------------------------------------
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_STAT_OFS = 12'h004;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LAST_LSB = 8;

  typedef enum logic [2:0] {
    DEV_RUN = 3'b001,
    DEV_SLEEP = 3'b010,
    DEV_WRST = 3'b100
  } sdc_dev_st_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_SHIFT = 3'b010,
    HST_GAP = 3'b100
  } sdc_hst_st_t;

endpackage

/* hw/sdc_link_if.sv */
`timescale 1ns/10ps
interface sdc_link_if;
  logic sck;
  logic cs_n;
  logic mosi;

  modport dev (
    input sck,
    input cs_n,
    input mosi
  );

  modport host (
    output sck,
    output cs_n,
    output mosi
  );
endinterface

/* hw/sdc_host.sv */
`timescale 1ns/10ps
module sdc_host
  import sdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sdc_link_if.host link
);

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  sdc_hst_st_t st_q;
  logic [15:0] last_q;
  logic [15:0] sh_q;
  logic [3:0] bit_q;
  logic [3:0] div_q;
  logic sck_q;
  logic cs_n_q;
  logic mosi_q;

  wire acc = psel & penable;
  wire xfer = acc & pready;
  wire sel_cmd = (paddr == HOST_CMD_OFS);
  wire sel_stat = (paddr == HOST_STAT_OFS);
  wire busy = (st_q != HST_IDLE);
  wire [31:0] stat_word = {8'h00, last_q, 7'h00, busy};
  // Write while a frame runs is dropped; poll busy first
  wire start = xfer & pwrite & sel_cmd & ~busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~(sel_cmd | sel_stat);
      prdata <= (acc & ~pready & ~pwrite & sel_stat) ? stat_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Serial transmit, mode 0, MSB first
  // ----------------------------------------
  wire tick = busy & (div_q == 4'(SPI_HALF_CYC - 1));
  wire last_bit = (bit_q == 4'(FRAME_BITS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'h0;
    end else if (!busy || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= HST_IDLE;
      last_q <= 16'h0000;
      sh_q <= 16'h0000;
      bit_q <= 4'h0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
    end else if (start) begin
      st_q <= HST_SHIFT;
      last_q <= pwdata[15:0];
      sh_q <= pwdata[15:0];
      mosi_q <= pwdata[15];
      bit_q <= 4'h0;
      cs_n_q <= 1'b0;
    end else if (tick && st_q == HST_SHIFT) begin
      sck_q <= ~sck_q;
      if (sck_q && last_bit) begin
        cs_n_q <= 1'b1;
        st_q <= HST_GAP;
      end else if (sck_q) begin
        sh_q <= {sh_q[14:0], 1'b0};
        mosi_q <= sh_q[14];
        bit_q <= bit_q + 4'h1;
      end
    end else if (tick && st_q == HST_GAP) begin
      // Keeps chip select high long enough for the far synchroniser
      st_q <= HST_IDLE;
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;

endmodule

/* dv/sdc_link_properties.sv */
`timescale 1ns/10ps
module sdc_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic vcc_wake,
  input wire logic asleep,
  input wire logic charge_fet_drive,
  input wire logic discharge_fet_drive,
  input wire logic regulated_supply_out,
  input wire logic od_protect
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------
  // Link framing
  // ----------------
  sequence s_sck_high;
    sck [*8] ##1 !sck;
  endsequence
  sequence s_first_rise;
    !sck [*7] ##[1:2] sck;
  endsequence
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("sck toggles while deselected");
  AST_SCK_HALF: assert property ($rose(sck) |-> s_sck_high)
    else $error("sck high phase not 8 cycles");
  AST_CS_LEAD: assert property ($fell(cs_n) |-> s_first_rise)
    else $error("first sck rise not 8 cycles after select");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("frame gap shorter than 8 cycles");
  AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while sck high");
  // ----------------
  // Device outputs
  // ----------------
  AST_SLEEP_OFF: assert property (asleep && $past(asleep) |->
    charge_fet_drive && discharge_fet_drive && !regulated_supply_out)
    else $error("outputs active in sleep");
  AST_OD_OFF: assert property (od_protect && $past(od_protect) |->
    charge_fet_drive && discharge_fet_drive)
    else $error("fet on in protection");
  AST_NO_SLEEP: assert property ($rose(asleep) |->
    !($past(vcc_wake, 2) && $past(vcc_wake, 3) && $past(vcc_wake, 4)))
    else $error("sleep entered with supply high");
  AST_WAKE: assert property (asleep && $rose(vcc_wake) |-> ##[1:8] !asleep)
    else $error("no wake on supply rise");
  AST_WAKE_REG: assert property ($fell(asleep) |-> regulated_supply_out)
    else $error("regulator off after wake");
endmodule

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import sdc_pkg::*;
  localparam int OD = 50;
  localparam int WK = 600;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, err;
  logic vw = 1'b0;
  logic bu = 1'b0;
  logic ce = 1'b0;
  logic cd, dd, ro, sl, od;
  logic [1:0] sel, s;
  logic [31:0] rd;
  int n_errors = 0;
  int total_checks = 0;
  int m_chg = 0, m_dsg = 0, m_gate = 0, m_sel = 0, m_sleep = 0, m_od = 0, m_wrst = 0;
  always #5 pclk = ~pclk;
  sdc_link_if link_if();
  sdc_dev #(.OD_CYC(OD), .WAKE_CYC(WK)) sdc_dev_inst (.pclk(pclk), .presetn(presetn),
    .link(link_if), .vcc_wake(vw), .cell_below_uv(bu), .cells_above_ce(ce),
    .charge_fet_drive(cd), .discharge_fet_drive(dd), .regulated_supply_out(ro),
    .charge_enable_threshold_sel(sel), .asleep(sl), .od_protect(od));
  sdc_host sdc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  sdc_link_properties sdc_link_properties_inst (.pclk(pclk), .presetn(presetn),
    .sck(link_if.sck), .cs_n(link_if.cs_n), .mosi(link_if.mosi), .vcc_wake(vw),
    .asleep(sl), .charge_fet_drive(cd), .discharge_fet_drive(dd),
    .regulated_supply_out(ro), .od_protect(od));
  // ----------------
  // Tasks
  // ----------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Model follows the frame only once it has surely landed in the device
  task automatic send(logic [7:0] ins, logic [7:0] dat);
    apb(1'b1, HOST_CMD_OFS, {16'($urandom), ins, dat});
    do apb(1'b0, HOST_STAT_OFS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    chk("stat", rd, {8'h00, ins, dat, 8'h00});
    repeat (8) @(posedge pclk);
    if (m_sleep == 0 && ins == CONTROL_WRITE_INSTR && m_wrst == 0) begin
      m_chg = dat[CTRL_CHG_BIT];
      m_dsg = dat[CTRL_DSG_BIT];
      if (m_dsg) m_od = 0;
      if (dat[CTRL_SLP_BIT] && !vw) begin
        m_sleep = 1;
        m_chg = 0;
        m_dsg = 0;
      end
    end
    if (m_sleep == 0 && ins == CONFIG_WRITE_INSTR) begin
      m_sel = dat[1:0];
      m_gate = dat[CFG_GATE_BIT];
    end
  endtask
  task automatic expect_out();
    logic run;
    run = !m_sleep && !m_wrst && !m_od && (m_gate || ce);
    chk("chg_drv", cd, !(run && m_chg));
    chk("dsg_drv", dd, !(run && m_dsg));
    chk("reg_out", ro, !m_sleep);
    chk("asleep", sl, m_sleep);
    chk("od", od, m_od);
    chk("sel", sel, m_sel);
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    void'($urandom(32'h971b));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    expect_out();
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", err, 1'b1);
    s = 2'($urandom_range(3, 0));
    send(CONFIG_WRITE_INSTR, {6'h00, s});
    send(CONTROL_WRITE_INSTR, 8'h03);
    expect_out();
    ce <= 1'b1;
    repeat (6) @(posedge pclk);
    expect_out();
    ce <= 1'b0;
    send(CONFIG_WRITE_INSTR, {5'h00, 1'b1, s});
    expect_out();
    vw <= 1'b1;
    send(CONTROL_WRITE_INSTR, 8'h80);
    expect_out();
    vw <= 1'b0;
    send(CONTROL_WRITE_INSTR, 8'h83);
    expect_out();
    send(CONTROL_WRITE_INSTR, 8'h03);
    expect_out();
    vw <= 1'b1;
    repeat (10) @(posedge pclk);
    m_sleep = 0;
    m_wrst = 1;
    expect_out();
    send(CONTROL_WRITE_INSTR, 8'h03);
    expect_out();
    repeat (WK) @(posedge pclk);
    m_wrst = 0;
    expect_out();
    send(CONTROL_WRITE_INSTR, 8'h03);
    expect_out();
    bu <= 1'b1;
    repeat (OD / 2) @(posedge pclk);
    bu <= 1'b0;
    repeat (OD) @(posedge pclk);
    expect_out();
    vw <= 1'b0;
    bu <= 1'b1;
    repeat (OD + 10) @(posedge pclk);
    {m_od, m_sleep, m_chg, m_dsg} = {32'd1, 32'd1, 32'd0, 32'd0};
    expect_out();
    send(CONFIG_WRITE_INSTR, 8'h00);
    expect_out();
    vw <= 1'b1;
    bu <= 1'b0;
    repeat (WK + 20) @(posedge pclk);
    m_sleep = 0;
    expect_out();
    send(CONTROL_WRITE_INSTR, 8'h03);
    expect_out();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    final_report();
  end
endmodule
